// ==== shared/cbx_defs.svh ====
// Purpose: Offsets, field positions and reset values of the execution unit
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: Memory window occupies the upper half of the address map
`ifndef CBX_DEFS_SVH
`define CBX_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CBX_OFF_CTRL 8'h00
`define CBX_OFF_STATUS 8'h04
`define CBX_OFF_INSN 8'h08
`define CBX_OFF_EXT 8'h0C
`define CBX_OFF_FLAGS 8'h10
`define CBX_OFF_PC 8'h14
`define CBX_OFF_OPERAND 8'h18
`define CBX_OFF_SRC 8'h1C
`define CBX_OFF_DST 8'h20
`define CBX_OFF_COUNT 8'h24
`define CBX_OFF_RET 8'h28
`define CBX_OFF_SAVED 8'h2C
`define CBX_OFF_DECODE 8'h30
`define CBX_MEM_BIT 7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CBX_CTRL_START 0
`define CBX_CTRL_WAKE 1
`define CBX_ST_BUSY 0
`define CBX_ST_DONE 1
`define CBX_ST_SLEEP 2
`define CBX_ST_TRAP 3
`define CBX_ST_TAKEN 4
`define CBX_ST_ILLEGAL 5
`define CBX_ST_EXTERR 6
`define CBX_FLAG_C 0
`define CBX_FLAG_V 1
`define CBX_FLAG_Z 2
`define CBX_FLAG_N 3

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define CBX_RST_PC 16'h0000
`define CBX_RST_FLAGS 8'h00
`define CBX_TRAP_BASE 16'h0010
`define CBX_INSN_BYTES 16'h0002
`define CBX_EXT16_BYTES 16'h0002
`define CBX_EXT32_BYTES 16'h0004
`define CBX_RESP_OKAY 2'b00
`define CBX_RESP_DECERR 2'b11

`endif

// ==== shared/cbx_pkg.sv ====
// Purpose: Types of the execution unit
// Assumes: Constants come from cbx_defs.svh
// Notes: Opcode values are the unit's own encoding
package cbx_pkg;

  typedef enum logic [3:0] {
    CBX_IDLE = 4'b0001,
    CBX_EXEC = 4'b0010,
    CBX_MOVE = 4'b0100,
    CBX_SLEEP = 4'b1000
  } cbx_state_t;

  typedef enum logic [3:0] {
    CBX_OP_MISC = 4'h0,
    CBX_OP_BIT = 4'h1,
    CBX_OP_BRANCH = 4'h2,
    CBX_OP_JUMP = 4'h3,
    CBX_OP_RCALL = 4'h4,
    CBX_OP_ACALL = 4'h5,
    CBX_OP_FLOGIC = 4'h6,
    CBX_OP_FLOAD = 4'h7,
    CBX_OP_FSTORE = 4'h8
  } cbx_op_t;

  typedef struct packed {
    logic [3:0] op;
    logic [3:0] sub;
    logic mem_sel;
    logic [2:0] areg;
    logic [3:0] dreg;
  } cbx_decode_t;

endpackage

// ==== rtl/cbx_exec_unit.sv ====
// Purpose: Bit-carry, branch, system-control and block-move execution unit
// Assumes: One instruction word plus extension loaded over AXI4-Lite
// Notes: Data memory is 32 bytes of flip-flops in the upper address half
//
// What this block does
// - Carry gets carry XOR bit, or inverted bit
// - Bit load copies bit or complement into carry
// - Carry store writes carry or complement to bit
// - Branch on always, never, C, Z, V, N, C|Z
// - Signed branches use N^V and Z|(N^V)
// - Unconditional jump takes its target unless a 24-bit extension has a nonzero upper byte
// - Calls save return point; return resumes there
// - Trap enters handler; exception return resumes flow
// - Sleep instruction enters power-down state
// - Flags load from operand; memory read as word
// - Flags store to destination; memory written as word
// - Flags AND, OR, XOR with 8-bit immediate
// - Idle only advances program counter by two
// - Byte-count move copies until count low zero
// - Word-count move uses full 16-bit count
// - Next instruction waits for move completion
// - Instructions are 2-byte units plus extension
// - Operation field is top four bits
// - Address register 3 bits, data register 4 bits
// - Extension is 16 or 32 bits
// - 24-bit extension needs upper byte zero
// - Condition field selects one of sixteen conditions
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "cbx_defs.svh"

module cbx_exec_unit import cbx_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cbx_state_t state_q;
  cbx_decode_t dec;
  logic [15:0] insn_q, pc_q, src_q, dst_q, count_q, ret_q, saved_pc_q;
  logic [31:0] ext_q;
  logic [7:0] flags_q, saved_flags_q, operand_q;
  logic [7:0] mem_q [0:31];
  logic done_q, trap_q, taken_q, illegal_q, exterr_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic wr_fire, wr_idle, rd_fire, wr_mapped, rd_mapped;
  logic [31:0] rd_word;
  logic [4:0] wr_idx;

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_idle = wr_fire && (state_q == CBX_IDLE);
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign wr_idx = awaddr_q[6:2];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic map_ok(input logic [7:0] a);
    return a[`CBX_MEM_BIT] || (a[1:0] == 2'b00 && a <= `CBX_OFF_DECODE);
  endfunction

  assign wr_mapped = map_ok(awaddr_q);
  assign rd_mapped = map_ok(s_axi_araddr);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `CBX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `CBX_RESP_OKAY : `CBX_RESP_DECERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr[`CBX_MEM_BIT]) begin
      rd_word = {24'h00_0000, mem_q[s_axi_araddr[6:2]]};
    end else begin
      case (s_axi_araddr)
        `CBX_OFF_STATUS: begin
          rd_word[`CBX_ST_BUSY] = (state_q != CBX_IDLE) && (state_q != CBX_SLEEP);
          rd_word[`CBX_ST_DONE] = done_q;
          rd_word[`CBX_ST_SLEEP] = (state_q == CBX_SLEEP);
          rd_word[`CBX_ST_TRAP] = trap_q;
          rd_word[`CBX_ST_TAKEN] = taken_q;
          rd_word[`CBX_ST_ILLEGAL] = illegal_q;
          rd_word[`CBX_ST_EXTERR] = exterr_q;
        end
        `CBX_OFF_INSN: rd_word = {16'h0000, insn_q};
        `CBX_OFF_EXT: rd_word = ext_q;
        `CBX_OFF_FLAGS: rd_word = {24'h00_0000, flags_q};
        `CBX_OFF_PC: rd_word = {16'h0000, pc_q};
        `CBX_OFF_OPERAND: rd_word = {24'h00_0000, operand_q};
        `CBX_OFF_SRC: rd_word = {16'h0000, src_q};
        `CBX_OFF_DST: rd_word = {16'h0000, dst_q};
        `CBX_OFF_COUNT: rd_word = {16'h0000, count_q};
        `CBX_OFF_RET: rd_word = {16'h0000, ret_q};
        `CBX_OFF_SAVED: rd_word = {8'h00, saved_flags_q, saved_pc_q};
        `CBX_OFF_DECODE: rd_word = {16'h0000, dec};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CBX_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_mapped ? `CBX_RESP_OKAY : `CBX_RESP_DECERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------------
  logic [15:0] next_pc, rel_target, pc_n;
  logic [7:0] flags_n, opnd_byte, mem_word_lo;
  logic sel_bit, cond, uses_ext, ext_ok, wr_reg, wr_mem, wr_bitval;
  logic fl_mem_wr, bad_op, take, go_sleep, go_move, do_trap, do_call, do_reti;
  logic start, move_zero;
  logic [4:0] mem_addr;

  assign dec = '{op: insn_q[15:12], sub: insn_q[11:8], mem_sel: insn_q[7],
                 areg: insn_q[6:4], dreg: insn_q[3:0]};
  assign mem_addr = ext_q[4:0];
  assign opnd_byte = dec.mem_sel ? mem_q[mem_addr] : operand_q;
  assign sel_bit = opnd_byte[dec.areg];
  assign mem_word_lo = mem_q[{mem_addr[4:1], 1'b0}];
  assign uses_ext = (dec.op == CBX_OP_JUMP) || (dec.op == CBX_OP_ACALL)
                    || ((dec.op == CBX_OP_BIT || dec.op == CBX_OP_FLOAD
                         || dec.op == CBX_OP_FSTORE) && dec.mem_sel);
  assign ext_ok = !(uses_ext && dec.dreg[3] && ext_q[31:24] != 8'h00);
  assign next_pc = pc_q + `CBX_INSN_BYTES + (!uses_ext ? 16'h0000
                   : dec.dreg[3] ? `CBX_EXT32_BYTES : `CBX_EXT16_BYTES);
  assign rel_target = next_pc + {{8{insn_q[7]}}, insn_q[7:0]};
  assign start = wr_idle && awaddr_q == `CBX_OFF_CTRL && wstrb_q[0]
                 && wdata_q[`CBX_CTRL_START];

  function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
    logic c, v, z, n;
    c = f[`CBX_FLAG_C];
    v = f[`CBX_FLAG_V];
    z = f[`CBX_FLAG_Z];
    n = f[`CBX_FLAG_N];
    case (cc)
      4'h0: return 1'b1;
      4'h1: return 1'b0;
      4'h2: return !(c | z);
      4'h3: return c | z;
      4'h4: return !c;
      4'h5: return c;
      4'h6: return !z;
      4'h7: return z;
      4'h8: return !v;
      4'h9: return v;
      4'hA: return !n;
      4'hB: return n;
      4'hC: return !(n ^ v);
      4'hD: return n ^ v;
      4'hE: return !(z | (n ^ v));
      default: return z | (n ^ v);
    endcase
  endfunction

  assign cond = cond_true(dec.sub, flags_q);

  always_comb begin
    flags_n = flags_q;
    pc_n = next_pc;
    wr_reg = 1'b0;
    wr_mem = 1'b0;
    wr_bitval = 1'b0;
    fl_mem_wr = 1'b0;
    bad_op = 1'b0;
    take = 1'b0;
    go_sleep = 1'b0;
    go_move = 1'b0;
    do_trap = 1'b0;
    do_call = 1'b0;
    do_reti = 1'b0;
    case (dec.op)
      CBX_OP_MISC: begin
        case (dec.sub)
          4'h0: ;
          4'h1: go_sleep = 1'b1;
          4'h2: begin
            do_reti = 1'b1;
            pc_n = saved_pc_q;
            flags_n = saved_flags_q;
          end
          4'h3: pc_n = ret_q;
          4'h4: begin
            do_trap = 1'b1;
            pc_n = `CBX_TRAP_BASE + {12'h000, insn_q[1:0], 2'b00};
          end
          4'h5, 4'h6: go_move = 1'b1;
          default: bad_op = 1'b1;
        endcase
      end
      CBX_OP_BIT: begin
        case (dec.sub)
          4'h0: flags_n[`CBX_FLAG_C] = flags_q[`CBX_FLAG_C] ^ sel_bit;
          4'h1: flags_n[`CBX_FLAG_C] = flags_q[`CBX_FLAG_C] ^ !sel_bit;
          4'h2: flags_n[`CBX_FLAG_C] = sel_bit;
          4'h3: flags_n[`CBX_FLAG_C] = !sel_bit;
          4'h4, 4'h5: begin
            wr_reg = !dec.mem_sel;
            wr_mem = dec.mem_sel;
            wr_bitval = flags_q[`CBX_FLAG_C] ^ dec.sub[0];
          end
          default: bad_op = 1'b1;
        endcase
      end
      CBX_OP_BRANCH: begin
        take = cond;
        if (cond) begin
          pc_n = rel_target;
        end
      end
      CBX_OP_JUMP: begin
        take = 1'b1;
        pc_n = ext_q[15:0];
      end
      CBX_OP_RCALL: begin
        do_call = 1'b1;
        pc_n = rel_target;
      end
      CBX_OP_ACALL: begin
        do_call = 1'b1;
        pc_n = ext_q[15:0];
      end
      CBX_OP_FLOGIC: begin
        case (dec.sub[1:0])
          2'b00: flags_n = flags_q & insn_q[7:0];
          2'b01: flags_n = flags_q | insn_q[7:0];
          2'b10: flags_n = flags_q ^ insn_q[7:0];
          default: bad_op = 1'b1;
        endcase
      end
      CBX_OP_FLOAD: flags_n = dec.mem_sel ? mem_word_lo : operand_q;
      CBX_OP_FSTORE: begin
        fl_mem_wr = dec.mem_sel;
        wr_reg = !dec.mem_sel;
      end
      default: bad_op = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  logic exec_ok;
  assign exec_ok = (state_q == CBX_EXEC) && !bad_op && ext_ok;
  assign move_zero = dec.sub[1] ? (count_q == 16'h0000) : (count_q[7:0] == 8'h00);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= CBX_IDLE;
    end else begin
      case (state_q)
        CBX_IDLE: if (start) state_q <= CBX_EXEC;
        CBX_EXEC: begin
          if (exec_ok && go_move) begin
            state_q <= CBX_MOVE;
          end else if (exec_ok && go_sleep) begin
            state_q <= CBX_SLEEP;
          end else begin
            state_q <= CBX_IDLE;
          end
        end
        CBX_MOVE: if (move_zero) state_q <= CBX_IDLE;
        CBX_SLEEP: begin
          if (wr_fire && awaddr_q == `CBX_OFF_CTRL && wstrb_q[0]
              && wdata_q[`CBX_CTRL_WAKE]) begin
            state_q <= CBX_IDLE;
          end
        end
        default: state_q <= CBX_IDLE;
      endcase
    end
  end

  // Status flags; completion set wins over software clear
  logic clr_st, finish;
  assign clr_st = wr_fire && awaddr_q == `CBX_OFF_STATUS && wstrb_q[0];
  assign finish = (state_q == CBX_EXEC && !(exec_ok && (go_move || go_sleep)))
                  || (state_q == CBX_MOVE && move_zero) || (state_q == CBX_EXEC && go_sleep);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      taken_q <= 1'b0;
      illegal_q <= 1'b0;
      exterr_q <= 1'b0;
    end else begin
      done_q <= finish || (done_q && !(clr_st && wdata_q[`CBX_ST_DONE]));
      illegal_q <= (state_q == CBX_EXEC && bad_op)
                   || (illegal_q && !(clr_st && wdata_q[`CBX_ST_ILLEGAL]));
      exterr_q <= (state_q == CBX_EXEC && !ext_ok)
                  || (exterr_q && !(clr_st && wdata_q[`CBX_ST_EXTERR]));
      if (state_q == CBX_EXEC) begin
        taken_q <= exec_ok && (take || do_call || do_trap);
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      trap_q <= 1'b0;
      saved_pc_q <= `CBX_RST_PC;
      saved_flags_q <= `CBX_RST_FLAGS;
      ret_q <= `CBX_RST_PC;
    end else if (exec_ok) begin
      if (do_trap) begin
        trap_q <= 1'b1;
        saved_pc_q <= next_pc;
        saved_flags_q <= flags_q;
      end
      if (do_reti) begin
        trap_q <= 1'b0;
      end
      if (do_call) begin
        ret_q <= next_pc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software-visible core registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      insn_q <= 16'h0000;
      ext_q <= 32'h0000_0000;
    end else if (wr_idle) begin
      if (awaddr_q == `CBX_OFF_INSN) insn_q <= 16'(merge({16'h0000, insn_q}, wdata_q, wstrb_q));
      if (awaddr_q == `CBX_OFF_EXT) ext_q <= merge(ext_q, wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flags_q <= `CBX_RST_FLAGS;
      pc_q <= `CBX_RST_PC;
    end else if (exec_ok) begin
      flags_q <= flags_n;
      pc_q <= pc_n;
    end else if (wr_idle) begin
      if (awaddr_q == `CBX_OFF_FLAGS && wstrb_q[0]) flags_q <= wdata_q[7:0];
      if (awaddr_q == `CBX_OFF_PC) pc_q <= 16'(merge({16'h0000, pc_q}, wdata_q, wstrb_q));
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      operand_q <= 8'h00;
    end else if (exec_ok && wr_reg && dec.op == CBX_OP_FSTORE) begin
      operand_q <= flags_q;
    end else if (exec_ok && wr_reg) begin
      operand_q[dec.areg] <= wr_bitval;
    end else if (wr_idle && awaddr_q == `CBX_OFF_OPERAND && wstrb_q[0]) begin
      operand_q <= wdata_q[7:0];
    end
  end

  // Block move pointers and count, one byte per cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      src_q <= 16'h0000;
      dst_q <= 16'h0000;
      count_q <= 16'h0000;
    end else if (state_q == CBX_MOVE && !move_zero) begin
      src_q <= src_q + 16'h0001;
      dst_q <= dst_q + 16'h0001;
      if (dec.sub[1]) begin
        count_q <= count_q - 16'h0001;
      end else begin
        count_q[7:0] <= count_q[7:0] - 8'h01;
      end
    end else if (wr_idle) begin
      if (awaddr_q == `CBX_OFF_SRC) src_q <= 16'(merge({16'h0000, src_q}, wdata_q, wstrb_q));
      if (awaddr_q == `CBX_OFF_DST) dst_q <= 16'(merge({16'h0000, dst_q}, wdata_q, wstrb_q));
      if (awaddr_q == `CBX_OFF_COUNT) begin
        count_q <= 16'(merge({16'h0000, count_q}, wdata_q, wstrb_q));
      end
    end
  end

  // ----------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 32; i++) begin : g_mem
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        mem_q[i] <= 8'h00;
      end else if (state_q == CBX_MOVE && !move_zero) begin
        if (dst_q[4:0] == 5'(i)) mem_q[i] <= mem_q[src_q[4:0]];
      end else if (exec_ok && wr_mem && mem_addr == 5'(i)) begin
        mem_q[i][dec.areg] <= wr_bitval;
      end else if (exec_ok && fl_mem_wr && mem_addr[4:1] == 4'(i >> 1)) begin
        mem_q[i] <= (i % 2 == 0) ? flags_q : 8'h00;
      end else if (wr_idle && awaddr_q[`CBX_MEM_BIT] && wr_idx == 5'(i) && wstrb_q[0]) begin
        mem_q[i] <= wdata_q[7:0];
      end
    end
  end

endmodule

// ==== tb/cbx_exec_sva.sv ====
// Purpose: Bus contract checks of the execution unit
// Assumes: Bound to cbx_exec_unit, one write and one read in flight
// Notes: Sees only top-level ports
`timescale 1ns/100ps
`include "cbx_defs.svh"
module cbx_exec_sva (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------
  // Bus contract
  // ----------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("Write response missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response repeated");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken while answering");
  r_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("Read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read data dropped");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read taken while answering");
  r_decerr_a: assert property (ar_taken ##0 (s_axi_araddr inside {[8'h34:8'h7c]}) |=>
    s_axi_rresp == `CBX_RESP_DECERR)
    else $error("Unmapped read not refused");
  r_okay_a: assert property (ar_taken ##0 (s_axi_araddr <= `CBX_OFF_DECODE) ##0
    (s_axi_araddr[1:0] == 2'b00) |=> s_axi_rresp == `CBX_RESP_OKAY)
    else $error("Mapped read refused");
endmodule
bind cbx_exec_unit cbx_exec_sva u_sva (.clock(clock), .resetn(resetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ==== tb/cpu_bitop_branch_sysctl_exec_bench.sv ====
// Purpose: Self-checking bench of the execution unit
// Assumes: Registers reached over AXI4-Lite from this module
// Notes: Expected values are worked out here
`timescale 1ns/100ps
`include "cbx_defs.svh"
module cpu_bitop_branch_sysctl_exec_bench;
  localparam logic [7:0] a_pc = `CBX_OFF_PC, a_fl = `CBX_OFF_FLAGS, a_in = `CBX_OFF_INSN;
  localparam logic [7:0] a_op = `CBX_OFF_OPERAND, a_ex = `CBX_OFF_EXT, a_st = `CBX_OFF_STATUS;
  logic clock = 1'b0, resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int failures = 0, comparisons = 0, cycles = 0;
  cbx_exec_unit uut (.clock(clock), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures = failures + 1;
      results();
    end
  end
  // ----------------
  // Bus and check tasks
  // ----------------
  task results;
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task exe(input logic [31:0] insn);
    wr(a_in, insn);
    wr(a_st, 32'h0000_0062);
    wr(`CBX_OFF_CTRL, 32'h0000_0001);
    do rd(a_st); while (rv[`CBX_ST_DONE] !== 1'b1);
  endtask
  function logic take(input logic [3:0] cc, input logic [3:0] f);
    logic c, v, z, n;
    c = f[`CBX_FLAG_C];
    v = f[`CBX_FLAG_V];
    z = f[`CBX_FLAG_Z];
    n = f[`CBX_FLAG_N];
    case (cc)
      4'h0: take = 1'b1;
      4'h1: take = 1'b0;
      4'h2: take = !(c | z);
      4'h3: take = c | z;
      4'h4: take = !c;
      4'h5: take = c;
      4'h6: take = !z;
      4'h7: take = z;
      4'h8: take = !v;
      4'h9: take = v;
      4'ha: take = !n;
      4'hb: take = n;
      4'hc: take = !(n ^ v);
      4'hd: take = n ^ v;
      4'he: take = !(z | (n ^ v));
      default: take = z | (n ^ v);
    endcase
  endfunction
  // ----------------
  // Scenarios
  // ----------------
  task t_branch;
    for (int i = 0; i < 256; i++) begin
      wr(a_fl, {28'h0, i[3:0]});
      wr(a_pc, 32'h0000_0100);
      exe({16'h0, 4'h2, i[7:4], 8'hf0});
      rd(a_pc);
      chk(rv, take(i[7:4], i[3:0]) ? 32'h0000_00f2 : 32'h0000_0102);
      rd(a_st);
      chk(rv[`CBX_ST_TAKEN], take(i[7:4], i[3:0]));
    end
  endtask
  task t_bits;
    logic [7:0] op;
    logic c;
    for (int i = 0; i < 48; i++) begin
      op = 8'ha5;
      c = 1'b1;
      case (i / 8)
        0: c = 1'b1 ^ op[i[2:0]];
        1: c = 1'b1 ^ ~op[i[2:0]];
        2: c = op[i[2:0]];
        3: c = ~op[i[2:0]];
        4: op[i[2:0]] = 1'b1;
        default: op[i[2:0]] = 1'b0;
      endcase
      wr(a_fl, 32'h0000_0001);
      wr(a_op, 32'h0000_00a5);
      exe({16'h0, 4'h1, 4'(i / 8), 1'b0, i[2:0], 4'h0});
      rd(a_fl);
      chk(rv, {31'h0, c});
      rd(a_op);
      chk(rv, {24'h0, op});
    end
  endtask
  task t_flags;
    logic [31:0] e[3] = '{32'h0000_0018, 32'h0000_007e, 32'h0000_0066};
    for (int k = 0; k < 3; k++) begin
      wr(a_fl, 32'h0000_005a);
      exe(32'h0000_603c | (k << 8));
      rd(a_fl);
      chk(rv, e[k]);
    end
    wr(a_op, 32'h0000_0096);
    exe(32'h0000_7000);
    rd(a_fl);
    chk(rv, 32'h0000_0096);
    wr(a_fl, 32'h0000_003c);
    exe(32'h0000_8000);
    rd(a_op);
    chk(rv, 32'h0000_003c);
    wr(a_pc, 32'h0000_0020);
    exe(32'h0000_0000);
    rd(a_pc);
    chk(rv, 32'h0000_0022);
    rd(a_fl);
    chk(rv, 32'h0000_003c);
  endtask
  task t_jump;
    logic [31:0] ex[4] = '{32'h0000_1234, 32'h0100_4444, 32'h0000_4444, 32'h0};
    logic [31:0] in[4] = '{32'h3000, 32'h3008, 32'h3008, 32'h0};
    for (int k = 0; k < 3; k++) begin
      wr(a_ex, ex[k]);
      exe(in[k]);
      rd(a_pc);
      chk(rv, k == 2 ? 32'h0000_4444 : 32'h0000_1234);
    end
    wr(a_pc, 32'h0000_0040);
    exe(32'h0000_4010);
    rd(a_pc);
    chk(rv, 32'h0000_0052);
    exe(32'h0000_0300);
    rd(a_pc);
    chk(rv, 32'h0000_0042);
    wr(a_pc, 32'h0000_0060);
    exe(32'h0000_0402);
    rd(a_pc);
    chk(rv, 32'h0000_0018);
    exe(32'h0000_0200);
    rd(a_pc);
    chk(rv, 32'h0000_0062);
  endtask
  task t_move;
    for (int i = 0; i < 3; i++) wr(8'(8'h80 + 4 * i), 32'h11 * (i + 1));
    wr(`CBX_OFF_SRC, 32'h0);
    wr(`CBX_OFF_DST, 32'h8);
    wr(`CBX_OFF_COUNT, 32'h0000_0103);
    exe(32'h0000_0500);
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'ha0 + 4 * i));
      chk(rv, i < 3 ? 32'h11 * (i + 1) : 32'h0);
    end
    rd(`CBX_OFF_COUNT);
    chk(rv, 32'h0000_0100);
    wr(`CBX_OFF_COUNT, 32'h0);
    exe(32'h0000_0600);
    rd(`CBX_OFF_SRC);
    chk(rv, 32'h0000_0003);
    wr(`CBX_OFF_COUNT, 32'h0000_0101);
    exe(32'h0000_0600);
    rd(`CBX_OFF_COUNT);
    chk(rv, 32'h0);
  endtask
  task t_sleep;
    wr(a_in, 32'h0000_0100);
    wr(`CBX_OFF_CTRL, 32'h0000_0001);
    rd(a_st);
    chk(rv[`CBX_ST_SLEEP], 1'b1);
    wr(`CBX_OFF_CTRL, 32'h0000_0002);
    rd(a_st);
    chk(rv[`CBX_ST_SLEEP], 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    rd(a_pc);
    chk(rv, 32'h0);
    rd(8'h40);
    chk({30'h0, rr}, {30'h0, `CBX_RESP_DECERR});
    t_branch();
    t_bits();
    t_flags();
    t_jump();
    t_move();
    t_sleep();
    results();
  end
endmodule
